// ### mai_apb_bfm.sv
// APB master model standing in for the program sequencer
module mai_apb_bfm (
  input  wire         pclk,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input  wire  [31:0] prdata,
  input  wire         pready,
  input  wire         pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // One transfer; the request stands until the rising edge at which pready is seen high,
  // and the answer is taken at that same edge, before the slave's flops update
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    // Released on the edge that completed the transfer
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;  // Stale data is scrambled so nothing leans on it
  endtask
endmodule

// ### mai_core.v
// ALU execution block for a subset of the 8-bit instruction set, with APB register access
//
// The implementer's own choices: the address map and register access over APB.
`include "mai_regs.vh"
module mai_core #(
  parameter       PC_W       = 13,     // Program counter width
  parameter       SP_W       = 3,      // Stack pointer width
  parameter       STK_DEPTH  = 8,      // Return stack entries
  parameter [7:0] PCL_ADDR   = 8'h06,  // Memory address aliased to program counter low
  parameter       WDT_PRESC  = 256,    // Clock cycles per watchdog tick
  parameter       WDT_LIMIT  = 256     // Watchdog ticks until time-out
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr
);

  // Architectural state
  reg  [7:0]      work;                  // Work register
  reg             flag_c;                // Carry
  reg             flag_ac;               // Nibble carry
  reg             flag_z;                // Zero result
  reg             flag_ov;               // Signed wrap
  reg             flag_sc;               // Signed compare
  reg             flag_to;               // Watchdog time-out
  reg             flag_pdf;              // Power-down
  reg  [PC_W-1:0] pc;                    // Program counter
  reg  [SP_W-1:0] sp;                    // Next free stack slot
  reg  [PC_W-1:0] stk [0:STK_DEPTH-1];   // Return stack
  reg  [7:0]      mem [0:255];           // Data memory
  reg             busy;                  // Dummy cycle of a two-cycle instruction
  reg             halted;                // Power-down state
  reg  [4:0]      last_op;               // Last issued opcode
  reg  [7:0]      opnd_addr;             // Memory operand address
  reg  [7:0]      opnd_imm;              // Immediate operand
  reg  [2:0]      opnd_bit;              // Bit index
  reg  [PC_W-1:0] target;                // Jump and call target
  reg  [15:0]     presc;                 // Watchdog prescaler
  reg  [15:0]     wdt_cnt;               // Watchdog count
  reg             rd_done;               // Read data is ready

  localparam [PC_W-1:0] PC_ONE   = 1;
  localparam [SP_W-1:0] SP_ONE   = 1;
  localparam [15:0]     PRESC_END = WDT_PRESC - 1;
  localparam [15:0]     WDT_END   = WDT_LIMIT - 1;

  // Bus decode
  wire        acc_ph   = psel & penable;
  wire        sel_cmd  = (paddr == `MAI_CMD_OFS);
  wire        sel_opnd = (paddr == `MAI_OPND_OFS);
  wire        sel_tgt  = (paddr == `MAI_TGT_OFS);
  wire        sel_work = (paddr == `MAI_WORK_OFS);
  wire        sel_stat = (paddr == `MAI_STAT_OFS);
  wire        sel_pc   = (paddr == `MAI_PC_OFS);
  wire        sel_stk  = (paddr == `MAI_STK_OFS);
  wire        sel_wdt  = (paddr == `MAI_WDT_OFS);
  wire        sel_mem  = paddr[11:10] == 2'b01;
  wire [7:0]  mem_idx  = paddr[9:2];
  wire        mapped   = sel_cmd | sel_opnd | sel_tgt | sel_work | sel_stat | sel_pc |
                         sel_stk | sel_wdt | sel_mem;
  wire [4:0]  cmd_op   = pwdata[4:0];
  wire        op_ok    = cmd_op <= `MAI_OP_NOP;

  // A command write waits for the dummy cycle to end; reads need one extra cycle
  assign pready  = pwrite ? ~(sel_cmd & busy) : rd_done;
  // Unmapped address, bad opcode or command while powered down answers an error
  assign pslverr = acc_ph & pready & (~mapped | (pwrite & sel_cmd & (~op_ok | halted)));

  wire wr_ok  = acc_ph & pwrite & pready & mapped;
  wire issue  = wr_ok & sel_cmd & op_ok & ~halted;

  // Memory operand; the program counter low alias reads the live counter
  wire [7:0] m_raw  = mem[opnd_addr];
  wire [7:0] m_op   = (opnd_addr == PCL_ADDR) ? pc[7:0] : m_raw;
  wire [PC_W-1:0] pc_inc = pc + PC_ONE;

  // Shared adder for the add family
  reg  [7:0]  add_b;
  reg         add_cin;
  wire [8:0]  sum9 = {1'b0, work} + {1'b0, add_b} + {8'h00, add_cin};
  wire [4:0]  nib5 = {1'b0, work[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
  wire        s_ov = (work[7] == add_b[7]) & (sum9[7] != work[7]);

  // Decimal adjust correction
  wire        da_lo  = (work[3:0] > 4'h9) | flag_ac;
  wire        da_hi  = (work[7:4] > 4'h9) | flag_c;
  wire [7:0]  da_cor = {1'b0, da_hi, da_hi, 1'b0, 1'b0, da_lo, da_lo, 1'b0};
  wire [8:0]  da_sum = {1'b0, work} + {1'b0, da_cor};

  // Execution results of the command being issued
  reg  [7:0]  x_res;      // Result byte
  reg         x_wr_work;  // Result goes to work register
  reg         x_wr_mem;   // Result goes to memory
  reg         x_arith;    // Five arithmetic flags update
  reg         x_zonly;    // Zero flag updates alone
  reg         x_daa;      // Carry from decimal adjust
  reg         x_jump;     // Load target
  reg         x_call;     // Push return address
  reg         x_wdtclr;   // Watchdog clear
  reg         x_halt;     // Enter power-down
  reg         x_two;      // Two-cycle instruction

  // Decode and compute the result combinationally from the written opcode
  always @*
  begin
    add_b     = m_op;
    add_cin   = 1'b0;
    x_res     = 8'h00;
    x_wr_work = 1'b0;
    x_wr_mem  = 1'b0;
    x_arith   = 1'b0;
    x_zonly   = 1'b0;
    x_daa     = 1'b0;
    x_jump    = 1'b0;
    x_call    = 1'b0;
    x_wdtclr  = 1'b0;
    x_halt    = 1'b0;
    case (cmd_op)
      `MAI_OP_ADC:
      begin
        add_cin   = flag_c;
        x_res     = sum9[7:0];
        x_wr_work = 1'b1;
        x_arith   = 1'b1;
      end
      `MAI_OP_ADD_CARRY_INTO_MEM:
      begin
        add_cin   = flag_c;
        x_res     = sum9[7:0];
        x_wr_mem  = 1'b1;
        x_arith   = 1'b1;
      end
      `MAI_OP_ADD_M:
      begin
        x_res     = sum9[7:0];
        x_wr_work = 1'b1;
        x_arith   = 1'b1;
      end
      `MAI_OP_ADD_X:
      begin
        add_b     = opnd_imm;
        x_res     = sum9[7:0];
        x_wr_work = 1'b1;
        x_arith   = 1'b1;
      end
      `MAI_OP_ADD_INTO_MEM:
      begin
        x_res     = sum9[7:0];
        x_wr_mem  = 1'b1;
        x_arith   = 1'b1;
      end
      `MAI_OP_AND_M:
      begin
        x_res     = work & m_op;
        x_wr_work = 1'b1;
        x_zonly   = 1'b1;
      end
      `MAI_OP_AND_X:
      begin
        x_res     = work & opnd_imm;
        x_wr_work = 1'b1;
        x_zonly   = 1'b1;
      end
      `MAI_OP_CALL:
      begin
        x_jump    = 1'b1;
        x_call    = 1'b1;
      end
      `MAI_OP_CLR:
      begin
        x_res     = 8'h00;
        x_wr_mem  = 1'b1;
      end
      `MAI_OP_CLRB:
      begin
        x_res     = m_op & ~(8'h01 << opnd_bit);
        x_wr_mem  = 1'b1;
      end
      `MAI_OP_CLRWDT:
        x_wdtclr  = 1'b1;
      `MAI_OP_CPL:
      begin
        x_res     = ~m_op;
        x_wr_mem  = 1'b1;
        x_zonly   = 1'b1;
      end
      `MAI_OP_COMPLEMENT_TO_WORK:
      begin
        x_res     = ~m_op;
        x_wr_work = 1'b1;
        x_zonly   = 1'b1;
      end
      `MAI_OP_DAA:
      begin
        x_res     = da_sum[7:0];
        x_wr_mem  = 1'b1;
        x_daa     = 1'b1;
      end
      `MAI_OP_DEC:
      begin
        x_res     = m_op - 8'h01;
        x_wr_mem  = 1'b1;
        x_zonly   = 1'b1;
      end
      `MAI_OP_MINUS_ONE_TO_WORK:
      begin
        x_res     = m_op - 8'h01;
        x_wr_work = 1'b1;
        x_zonly   = 1'b1;
      end
      `MAI_OP_HALT:
        x_halt    = 1'b1;
      `MAI_OP_INC:
      begin
        x_res     = m_op + 8'h01;
        x_wr_mem  = 1'b1;
        x_zonly   = 1'b1;
      end
      `MAI_OP_PLUS_ONE_TO_WORK:
      begin
        x_res     = m_op + 8'h01;
        x_wr_work = 1'b1;
        x_zonly   = 1'b1;
      end
      `MAI_OP_JMP:
        x_jump    = 1'b1;
      `MAI_OP_MOV_AM:
      begin
        x_res     = m_op;
        x_wr_work = 1'b1;
      end
      `MAI_OP_MOV_AX:
      begin
        x_res     = opnd_imm;
        x_wr_work = 1'b1;
      end
      `MAI_OP_MOV_MA:
      begin
        x_res     = work;
        x_wr_mem  = 1'b1;
      end
      default:
        x_res     = 8'h00; // No operation
    endcase
    // A write into program counter low or any branch needs a refetch cycle
    x_two = x_jump | (x_wr_mem & (opnd_addr == PCL_ADDR));
  end

  wire pcl_wr = x_wr_mem & (opnd_addr == PCL_ADDR);

  // Watchdog tick and time-out; while halted it keeps running and wakes the core
  wire tick    = (presc == PRESC_END);
  wire timeout = tick & (wdt_cnt == WDT_END);
  wire wdt_rst = issue & (x_wdtclr | x_halt);

  // Watchdog prescaler and count
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      presc   <= 16'h0000;
      wdt_cnt <= 16'h0000;
    end
    else if (wdt_rst)
    begin
      // Clear restarts both stages
      presc   <= 16'h0000;
      wdt_cnt <= 16'h0000;
    end
    else
    begin
      presc <= tick ? 16'h0000 : presc + 16'h0001;
      if (tick)
        wdt_cnt <= timeout ? 16'h0000 : wdt_cnt + 16'h0001;
    end
  end

  // Work register, flags, sequencing state and software-visible registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      work      <= `MAI_WORK_RST;
      {flag_pdf, flag_to, flag_sc, flag_ov, flag_z, flag_ac, flag_c} <= `MAI_FLAG_RST;
      pc        <= {PC_W{1'b0}};
      sp        <= {SP_W{1'b0}};
      busy      <= 1'b0;
      halted    <= 1'b0;
      last_op   <= 5'h00;
      opnd_addr <= 8'h00;
      opnd_imm  <= 8'h00;
      opnd_bit  <= 3'h0;
      target    <= {PC_W{1'b0}};
    end
    else
    begin
      // The dummy cycle lasts exactly one clock
      busy <= issue & x_two;
      // Software access to plain registers
      if (wr_ok & sel_opnd)
      begin
        opnd_addr <= pwdata[`MAI_OP_ADDR_LSB +: 8];
        opnd_imm  <= pwdata[`MAI_OP_IMM_LSB +: 8];
        opnd_bit  <= pwdata[`MAI_OP_BIT_LSB +: 3];
      end
      if (wr_ok & sel_tgt)
        target <= pwdata[PC_W-1:0];
      if (wr_ok & sel_work)
        work <= pwdata[7:0];
      if (wr_ok & sel_pc)
        pc <= pwdata[PC_W-1:0];
      if (wr_ok & sel_stat)
      begin
        {flag_pdf, flag_to, flag_sc, flag_ov, flag_z, flag_ac, flag_c} <= pwdata[6:0];
        if (pwdata[`MAI_ST_HALT])
          halted <= 1'b0;
      end
      // Instruction commit
      if (issue)
      begin
        last_op <= cmd_op;
        if (x_wr_work)
          work <= x_res;
        if (x_arith)
        begin
          flag_c  <= sum9[8];
          flag_ac <= nib5[4];
          flag_z  <= (sum9[7:0] == 8'h00);
          flag_ov <= s_ov;
          flag_sc <= sum9[7] ^ s_ov;
        end
        if (x_zonly)
          flag_z <= (x_res == 8'h00);
        // Carry only rises, for multi-byte decimal sums
        if (x_daa & (da_hi | da_sum[8]))
          flag_c <= 1'b1;
        if (x_wdtclr)
        begin
          flag_to  <= 1'b0;
          flag_pdf <= 1'b0;
        end
        if (x_halt)
        begin
          halted   <= 1'b1;
          flag_pdf <= 1'b1;
          flag_to  <= 1'b0;
        end
        // Program counter: branch, alias write or step
        if (x_jump)
          pc <= target;
        else if (pcl_wr)
          pc <= {pc[PC_W-1:8], x_res};
        else
          pc <= pc_inc;
        if (x_call)
          sp <= sp + SP_ONE;
      end
      // A time-out wins over any clear in the same cycle and ends power-down
      if (timeout)
      begin
        flag_to <= 1'b1;
        halted  <= 1'b0;
      end
    end
  end

  // Data memory and return stack write port; a command and a bus write never coincide
  always @(posedge pclk)
  begin
    if (issue & x_wr_mem)
      mem[opnd_addr] <= x_res;
    else if (wr_ok & sel_mem)
      mem[mem_idx] <= pwdata[7:0];
    if (issue & x_call)
      stk[sp] <= pc_inc;
  end

  // Read data is registered, so each read takes one wait cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_done <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      rd_done <= acc_ph & ~pwrite & ~rd_done;
      if (acc_ph & ~pwrite & ~rd_done)
      begin
        prdata <= 32'h0000_0000;
        if (sel_cmd)
          prdata[4:0] <= last_op;
        if (sel_opnd)
          prdata[18:0] <= {opnd_bit, opnd_imm, opnd_addr};
        if (sel_tgt)
          prdata[PC_W-1:0] <= target;
        if (sel_work)
          prdata[7:0] <= work;
        if (sel_stat)
          prdata[9:0] <= {halted, busy, 1'b0, flag_pdf, flag_to, flag_sc, flag_ov,
                          flag_z, flag_ac, flag_c};
        if (sel_pc)
          prdata[PC_W-1:0] <= pc;
        if (sel_stk)
        begin
          prdata[PC_W-1:0]       <= stk[sp - SP_ONE];
          prdata[16+SP_W-1:16]   <= sp;
        end
        if (sel_wdt)
          prdata[15:0] <= wdt_cnt;
        if (sel_mem)
          prdata[7:0] <= (mem_idx == PCL_ADDR) ? pc[7:0] : mem[mem_idx];
      end
    end
  end

endmodule

// ### mai_core_chk.sv
// Bus-level assertions for the ALU execution block
`include "mai_regs.vh"
module mai_core_chk #(
  parameter WDT_PRESC = 256,  // Clock cycles per watchdog tick
  parameter WDT_LIMIT = 256   // Watchdog ticks until time-out
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc    = psel && penable;                       // Access phase
  wire cmd_wr = acc && pwrite && (paddr == `MAI_CMD_OFS); // Command issue
  wire idle_r = !psel || pwrite;                       // No read under way
  int  halt_age;                                       // Cycles since halt, 0 after reset or a wake write; keeps counting after a time-out

  // Halt can only end by a wake write or a full watchdog period, so track it
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      halt_age <= 0;
    else if (cmd_wr && pready && !pslverr && pwdata[4:0] == `MAI_OP_HALT)
      halt_age <= 1;
    else if (acc && pwrite && pready && paddr == `MAI_STAT_OFS && pwdata[9])
      halt_age <= 0;
    else if (halt_age != 0)
      halt_age <= halt_age + 1;
  end

  // First cycle of a read access phase
  sequence rd_first;
    psel && penable && !pwrite && !$past(penable);
  endsequence

  a_read_wait: assert property (rd_first |-> !pready ##1 pready)
    else $error("read answer not after exactly one wait");
  a_write_ready: assert property (acc && pwrite && paddr != `MAI_CMD_OFS |-> pready)
    else $error("register write was stalled");
  a_bad_opcode: assert property (cmd_wr && pready && pwdata[4:0] > 5'h17 |-> pslverr)
    else $error("undefined opcode accepted");
  a_unmapped_err: assert property (acc && pready && paddr > `MAI_WDT_OFS
    && paddr < `MAI_MEM_BASE |-> pslverr)
    else $error("unmapped address accepted");
  a_mem_no_err: assert property (acc && pready && paddr >= `MAI_MEM_BASE
    && paddr < 12'h800 |-> !pslverr)
    else $error("data memory access refused");
  a_err_with_ready: assert property (acc && !pready |-> !pslverr)
    else $error("error raised without ready");
  a_rdata_hold: assert property (idle_r && $past(idle_r) |-> $stable(prdata))
    else $error("read data changed outside a read");
  a_halt_refuse: assert property (cmd_wr && pready && halt_age != 0
    && halt_age < WDT_PRESC * WDT_LIMIT - 1 |-> pslverr)
    else $error("command accepted while halted");
endmodule

bind mai_core mai_core_chk #(.WDT_PRESC(WDT_PRESC), .WDT_LIMIT(WDT_LIMIT)) mai_core_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ### mai_regs.vh
// Register offsets, field positions, opcodes and reset values of the ALU execution block
`ifndef MAI_REGS_VH
`define MAI_REGS_VH
// Register byte offsets on the 12-bit APB address
`define MAI_CMD_OFS      12'h000
`define MAI_OPND_OFS     12'h004
`define MAI_TGT_OFS      12'h008
`define MAI_WORK_OFS     12'h00C
`define MAI_STAT_OFS     12'h010
`define MAI_PC_OFS       12'h014
`define MAI_STK_OFS      12'h018
`define MAI_WDT_OFS      12'h01C
`define MAI_MEM_BASE     12'h400
// Status register bit positions
`define MAI_ST_C         0
`define MAI_ST_AC        1
`define MAI_ST_Z         2
`define MAI_ST_OV        3
`define MAI_ST_SC        4
`define MAI_ST_TO        5
`define MAI_ST_PDF       6
`define MAI_ST_BUSY      8
`define MAI_ST_HALT      9
// Reset values
`define MAI_WORK_RST     8'h00
`define MAI_FLAG_RST     7'h00
// Operand register fields
`define MAI_OP_ADDR_LSB  0
`define MAI_OP_IMM_LSB   8
`define MAI_OP_BIT_LSB   16
// Opcodes written into the command register
`define MAI_OP_ADC       5'h00
`define MAI_OP_ADD_CARRY_INTO_MEM      5'h01
`define MAI_OP_ADD_M     5'h02
`define MAI_OP_ADD_X     5'h03
`define MAI_OP_ADD_INTO_MEM      5'h04
`define MAI_OP_AND_M     5'h05
`define MAI_OP_AND_X     5'h06
`define MAI_OP_CALL      5'h07
`define MAI_OP_CLR       5'h08
`define MAI_OP_CLRB      5'h09
`define MAI_OP_CLRWDT    5'h0A
`define MAI_OP_CPL       5'h0B
`define MAI_OP_COMPLEMENT_TO_WORK      5'h0C
`define MAI_OP_DAA       5'h0D
`define MAI_OP_DEC       5'h0E
`define MAI_OP_MINUS_ONE_TO_WORK      5'h0F
`define MAI_OP_HALT      5'h10
`define MAI_OP_INC       5'h11
`define MAI_OP_PLUS_ONE_TO_WORK      5'h12
`define MAI_OP_JMP       5'h13
`define MAI_OP_MOV_AM    5'h14
`define MAI_OP_MOV_AX    5'h15
`define MAI_OP_MOV_MA    5'h16
`define MAI_OP_NOP       5'h17
`endif

// ### tb_mai_core.sv
// Self-checking bench for the ALU execution block
`include "mai_regs.vh"
module tb_mai_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  wire         psel, penable, pwrite, pready, pslverr;
  wire  [11:0] paddr;
  wire  [31:0] pwdata, prdata;
  int          err_total = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [31:0] q;
  logic        e;
  localparam [11:0] MEM = 12'h440;  // Data memory byte 16

  always #2.5 pclk = ~pclk;
  // Hang guard, well above the expected run length
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      stop_test();
    end
  end

  // Small watchdog period so the time-out is reachable
  mai_core #(.WDT_PRESC(64), .WDT_LIMIT(64)) mai_core_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  mai_apb_bfm bfm (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bfm.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    bfm.xfer(1'b0, a, 32'h0000_0000, d, e);
  endtask
  task automatic cmd(input logic [4:0] op, input logic [31:0] opnd);
    wr(`MAI_OPND_OFS, opnd);
    wr(`MAI_CMD_OFS, {27'h0, op});
  endtask
  // Load work, memory byte and flags, issue one opcode, check all three
  task automatic run(input logic [4:0] op, input logic [7:0] w, m, input logic [6:0] st,
                     input logic [10:0] bi, input logic [7:0] ew, em, input logic [6:0] est);
    wr(`MAI_WORK_OFS, {24'h0, w});
    wr(MEM, {24'h0, m});
    cmd(`MAI_OP_CLRWDT, 32'h0000_0000);
    wr(`MAI_STAT_OFS, {25'h0, st});
    cmd(op, {13'h0, bi, 8'h10});
    rd(`MAI_WORK_OFS, q);
    chk({24'h0, q[7:0]}, {24'h0, ew});
    rd(MEM, q);
    chk({24'h0, q[7:0]}, {24'h0, em});
    rd(`MAI_STAT_OFS, q);
    chk(q & 32'h0000_037F, {25'h0, est});
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`MAI_STAT_OFS, q);
    chk(q, 32'h0000_0000);
    bfm.xfer(1'b0, 12'h020, 32'h0000_0000, q, e);
    chk({31'h0, e}, 32'h0000_0001);
    bfm.xfer(1'b1, `MAI_CMD_OFS, 32'h0000_0018, q, e);
    chk({31'h0, e}, 32'h0000_0001);
    $display("test reset and refusals done");
    run(`MAI_OP_ADC, 8'h3A, 8'h25, 7'h01, 11'h000, 8'h60, 8'h25, 7'h02);
    run(`MAI_OP_ADD_CARRY_INTO_MEM, 8'hFF, 8'h00, 7'h01, 11'h000, 8'hFF, 8'h00, 7'h07);
    run(`MAI_OP_ADD_M, 8'h80, 8'h80, 7'h01, 11'h000, 8'h00, 8'h80, 7'h1D);
    run(`MAI_OP_ADD_X, 8'h7F, 8'h55, 7'h00, 11'h001, 8'h80, 8'h55, 7'h0A);
    run(`MAI_OP_ADD_INTO_MEM, 8'h11, 8'h22, 7'h01, 11'h000, 8'h11, 8'h33, 7'h00);
    run(`MAI_OP_AND_M, 8'hF0, 8'h0F, 7'h1B, 11'h000, 8'h00, 8'h0F, 7'h1F);
    run(`MAI_OP_AND_X, 8'hF0, 8'h0F, 7'h04, 11'h03C, 8'h30, 8'h0F, 7'h00);
    run(`MAI_OP_CLR, 8'h12, 8'hA5, 7'h1F, 11'h000, 8'h12, 8'h00, 7'h1F);
    run(`MAI_OP_CLRB, 8'h12, 8'hFF, 7'h00, 11'h300, 8'h12, 8'hF7, 7'h00);
    run(`MAI_OP_CLRB, 8'h12, 8'h80, 7'h00, 11'h700, 8'h12, 8'h00, 7'h00);
    run(`MAI_OP_CPL, 8'h12, 8'hFF, 7'h00, 11'h000, 8'h12, 8'h00, 7'h04);
    run(`MAI_OP_COMPLEMENT_TO_WORK, 8'h12, 8'h0F, 7'h04, 11'h000, 8'hF0, 8'h0F, 7'h00);
    run(`MAI_OP_DAA, 8'h45, 8'h00, 7'h00, 11'h000, 8'h45, 8'h45, 7'h00);
    run(`MAI_OP_DAA, 8'h45, 8'h00, 7'h02, 11'h000, 8'h45, 8'h4B, 7'h02);
    run(`MAI_OP_DAA, 8'hA3, 8'h00, 7'h00, 11'h000, 8'hA3, 8'h03, 7'h01);
    run(`MAI_OP_DAA, 8'h12, 8'h00, 7'h03, 11'h000, 8'h12, 8'h78, 7'h03);
    run(`MAI_OP_DEC, 8'h12, 8'h01, 7'h00, 11'h000, 8'h12, 8'h00, 7'h04);
    run(`MAI_OP_MINUS_ONE_TO_WORK, 8'h12, 8'h00, 7'h04, 11'h000, 8'hFF, 8'h00, 7'h00);
    run(`MAI_OP_INC, 8'h12, 8'hFF, 7'h01, 11'h000, 8'h12, 8'h00, 7'h05);
    run(`MAI_OP_PLUS_ONE_TO_WORK, 8'h12, 8'h7F, 7'h04, 11'h000, 8'h80, 8'h7F, 7'h00);
    run(`MAI_OP_MOV_AM, 8'h12, 8'h5A, 7'h1F, 11'h000, 8'h5A, 8'h5A, 7'h1F);
    run(`MAI_OP_MOV_AX, 8'h12, 8'h5A, 7'h04, 11'h0C3, 8'hC3, 8'h5A, 7'h04);
    run(`MAI_OP_MOV_MA, 8'h00, 8'h77, 7'h00, 11'h000, 8'h00, 8'h00, 7'h00);
    $display("test data operations done");
    wr(`MAI_PC_OFS, 32'h0000_0100);
    wr(`MAI_TGT_OFS, 32'h0000_0ABC);
    cmd(`MAI_OP_CALL, 32'h0000_0000);
    rd(`MAI_PC_OFS, q);
    chk(q, 32'h0000_0ABC);
    rd(`MAI_STK_OFS, q);
    chk(q & 32'h0007_1FFF, 32'h0001_0101);
    wr(`MAI_TGT_OFS, 32'h0000_0123);
    cmd(`MAI_OP_JMP, 32'h0000_0000);
    rd(`MAI_PC_OFS, q);
    chk(q, 32'h0000_0123);
    wr(`MAI_WORK_OFS, 32'h0000_0044);
    cmd(`MAI_OP_MOV_MA, 32'h0000_0006);
    rd(`MAI_PC_OFS, q);
    chk(q, 32'h0000_0144);
    rd(`MAI_STAT_OFS, q);
    chk(q & 32'h0000_037F, 32'h0000_0000);
    $display("test program flow done");
    wr(`MAI_STAT_OFS, 32'h0000_0020);
    cmd(`MAI_OP_HALT, 32'h0000_0000);
    rd(`MAI_STAT_OFS, q);
    chk(q & 32'h0000_037F, 32'h0000_0240);
    rd(`MAI_WDT_OFS, q);
    chk(q, 32'h0000_0000);
    bfm.xfer(1'b1, `MAI_CMD_OFS, {27'h0, `MAI_OP_NOP}, q, e);
    chk({31'h0, e}, 32'h0000_0001);
    wr(`MAI_STAT_OFS, 32'h0000_0240);
    cmd(`MAI_OP_CLRWDT, 32'h0000_0000);
    rd(`MAI_STAT_OFS, q);
    chk(q & 32'h0000_037F, 32'h0000_0000);
    cmd(`MAI_OP_HALT, 32'h0000_0000);
    repeat (4136) @(posedge pclk);
    rd(`MAI_STAT_OFS, q);
    chk(q & 32'h0000_0220, 32'h0000_0020);
    $display("test halt and watchdog done");
    stop_test();
  end
endmodule
